// *** hw/ett_pkg.sv ***
/*
  ett_pkg: register indices, field positions and reset values of the
  eight-bit counter/timer.
  assumes: included by the single design module ett_timer8.
*/
package ett_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] ETT_CTRL_IDX = 8'h00;   // timer8_control
  localparam logic [7:0] ETT_LOW_IDX  = 8'h04;   // timer8_low_hold
  localparam logic [7:0] ETT_HIGH_IDX = 8'h05;   // timer8_high_hold
  localparam logic [7:0] ETT_AUX_IDX  = 8'h08;   // shared / pin bits
  localparam logic [7:0] ETT_STAT_IDX = 8'h09;   // live count, read only

  // ****************************************
  // timer8_control fields
  // ****************************************
  localparam int ETT_RUN_BIT    = 7;
  localparam int ETT_SINGLE_BIT = 6;
  localparam int ETT_FLAG_BIT   = 5;
  localparam int ETT_PRE_HI     = 4;
  localparam int ETT_PRE_LO     = 3;
  localparam int ETT_CAPM_BIT   = 2;
  localparam int ETT_TOM_BIT    = 1;
  localparam int ETT_PINSEL_BIT = 0;

  // ****************************************
  // auxiliary register fields
  // ****************************************
  localparam int ETT_INIT_BIT   = 0;   // initial-value bit D1 of shared control
  localparam int ETT_DEMOD_BIT  = 1;   // 1 = demodulation, 0 = transmit
  localparam int ETT_EDGSEL_BIT = 2;   // port2 bit0 feeds edge detection
  localparam int ETT_PDATA_BIT  = 3;   // ordinary port3 bit4 output data

  // status register: count in [7:0], output level at bit 8
  localparam int ETT_STAT_OUT_BIT = 8;

  // ****************************************
  // reset values and prescale masks
  // ****************************************
  localparam logic [7:0] ETT_HOLD_RST = 8'h00;
  localparam logic [3:0] ETT_AUX_RST  = 4'h0;
  localparam logic [1:0] ETT_PRE_RST  = 2'h0;
  localparam logic [2:0] ETT_MASK_D1  = 3'h0;
  localparam logic [2:0] ETT_MASK_D2  = 3'h1;
  localparam logic [2:0] ETT_MASK_D4  = 3'h3;
  localparam logic [2:0] ETT_MASK_D8  = 3'h7;

  typedef enum logic {ETT_IDLE, ETT_COUNT} ett_state_e;

endpackage : ett_pkg

// *** hw/ett_timer8.sv ***
/*
  ett_timer8: eight-bit counter/timer with high and low hold registers,
  control register, port3 bit4 output routing and port2 bit0 edge source,
  reached over APB.
  assumes: one clock ref_clk at 40 MHz, synchronous active-low power-on
  reset, stop_recovery is a one-cycle pulse from logic on ref_clk, the
  port2 bit0 pin is asynchronous.
*/
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
module ett_timer8
  import ett_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire logic              stop_recovery,
  input  wire logic              port2_bit0_pin,
  output logic                   port3_bit4_pin,
  output logic                   timer8_output,
  output logic                   timeout_irq,
  output logic                   capture_int_enable,
  output logic                   edge_sense,
  output logic                   edge_event
);

  // ****************************************
  // address decode
  // ****************************************
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    reg_hit = (a == ADDR_W'({idx, 2'b00}));
  endfunction

  logic              wr_en;
  logic              setup;
  logic              hit_ctrl;
  logic              hit_low;
  logic              hit_high;
  logic              hit_aux;
  logic              hit_stat;
  logic              run_ff;
  logic              single_ff;
  logic              flag_ff;
  logic [1:0]        pre_ff;
  logic              capm_ff;
  logic              tom_ff;
  logic              pinsel_ff;
  logic [7:0]        high_ff;
  logic [7:0]        low_ff;
  logic [3:0]        aux_ff;
  logic [7:0]        cnt_ff;
  logic              out_ff;
  logic [2:0]        div_ff;
  logic [2:0]        pre_mask;
  logic              tick;
  logic              load_ev;
  logic              term;
  logic [7:0]        ctrl_rd;
  logic [31:0]       nxt_rdata;
  logic              nxt_err;
  logic [31:0]       rdata_ff;
  logic              err_ff;
  logic              pin_ff;
  logic [2:0]        p20_sync_ff;
  logic              p20_ff;
  logic              edge_ev_ff;
  ett_state_e        state_ff;

  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign hit_ctrl = reg_hit(paddr, ETT_CTRL_IDX);
  assign hit_low  = reg_hit(paddr, ETT_LOW_IDX);
  assign hit_high = reg_hit(paddr, ETT_HIGH_IDX);
  assign hit_aux  = reg_hit(paddr, ETT_AUX_IDX);
  assign hit_stat = reg_hit(paddr, ETT_STAT_IDX);

  // ****************************************
  // apb slave, zero wait, data latched in setup
  // ****************************************
  assign pready  = 1'b1;
  assign prdata  = rdata_ff;
  assign pslverr = err_ff;

  // control register read image
  assign ctrl_rd = {run_ff, single_ff, flag_ff, pre_ff, capm_ff, tom_ff, pinsel_ff};

  // read mux and unmapped detection
  always_comb begin
    nxt_rdata = 32'h0;
    nxt_err   = 1'b0;
    if (hit_ctrl) begin
      nxt_rdata[7:0] = ctrl_rd;
    end else if (hit_low) begin
      nxt_rdata[7:0] = low_ff;
    end else if (hit_high) begin
      nxt_rdata[7:0] = high_ff;
    end else if (hit_aux) begin
      nxt_rdata[3:0] = aux_ff;
    end else if (hit_stat) begin
      nxt_rdata[7:0]              = cnt_ff;
      nxt_rdata[ETT_STAT_OUT_BIT] = out_ff;
    end else begin
      nxt_err = 1'b1;
    end
  end

  // read data and error registered at setup
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_ff <= 32'h0;
      err_ff   <= 1'b0;
    end else if (setup) begin
      rdata_ff <= pwrite ? 32'h0 : nxt_rdata;
      err_ff   <= nxt_err;
    end
  end

  // ****************************************
  // hold registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      high_ff <= ETT_HOLD_RST;
      low_ff  <= ETT_HOLD_RST;
    end else if (wr_en) begin
      if (hit_high) high_ff <= pwdata[7:0];
      if (hit_low)  low_ff  <= pwdata[7:0];
    end
  end

  // auxiliary bits: initial value, mode, edge select, port data
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      aux_ff <= ETT_AUX_RST;
    end else if (wr_en && hit_aux) begin
      aux_ff <= pwdata[3:0];
    end
  end

  // ****************************************
  // control register
  // ****************************************
  // enable, single pass and pin select: cleared by reset and recovery
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      run_ff    <= 1'b0;
      single_ff <= 1'b0;
      pinsel_ff <= 1'b0;
    end else if (stop_recovery) begin
      run_ff    <= 1'b0;
      single_ff <= 1'b0;
      pinsel_ff <= 1'b0;
    end else if (wr_en && hit_ctrl) begin
      run_ff    <= pwdata[ETT_RUN_BIT];
      single_ff <= pwdata[ETT_SINGLE_BIT];
      pinsel_ff <= pwdata[ETT_PINSEL_BIT];
    end else if (term && single_ff) begin
      run_ff    <= 1'b0;
    end
  end

  // prescale and masks: only power-on reset initialises them
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pre_ff  <= ETT_PRE_RST;
      capm_ff <= 1'b0;
      tom_ff  <= 1'b0;
    end else if (wr_en && hit_ctrl) begin
      pre_ff  <= pwdata[ETT_PRE_HI:ETT_PRE_LO];
      capm_ff <= pwdata[ETT_CAPM_BIT];
      tom_ff  <= pwdata[ETT_TOM_BIT];
    end
  end

  // time-out flag: set wins over a write-one clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else if (term) begin
      flag_ff <= 1'b1;
    end else if (wr_en && hit_ctrl && pwdata[ETT_FLAG_BIT]) begin
      flag_ff <= 1'b0;
    end
  end

  // ****************************************
  // prescaler
  // ****************************************
  always_comb begin
    case (pre_ff)
      2'h0:    pre_mask = ETT_MASK_D1;
      2'h1:    pre_mask = ETT_MASK_D2;
      2'h2:    pre_mask = ETT_MASK_D4;
      default: pre_mask = ETT_MASK_D8;
    endcase
  end

  // free divider, realigned on every start
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_ff == ETT_IDLE) begin
      div_ff <= 3'h0;
    end else begin
      div_ff <= div_ff + 3'h1;
    end
  end

  assign tick    = ((div_ff & pre_mask) == pre_mask);
  assign load_ev = (state_ff == ETT_IDLE) && run_ff;
  assign term    = (state_ff == ETT_COUNT) && run_ff && tick && (cnt_ff == 8'h00);

  // ****************************************
  // counter and output level
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_ff <= ETT_IDLE;
    end else begin
      case (state_ff)
        ETT_IDLE:  if (run_ff) state_ff <= ETT_COUNT;
        ETT_COUNT: if (!run_ff || (term && single_ff)) state_ff <= ETT_IDLE;
        default:   state_ff <= ETT_IDLE;
      endcase
    end
  end

  // count loads the hold register of the current level at start and of the other level at terminal
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_ff <= ETT_HOLD_RST;
    end else if (load_ev) begin
      cnt_ff <= out_ff ? high_ff : low_ff;
    end else if (term) begin
      cnt_ff <= out_ff ? low_ff : high_ff;
    end else if (state_ff == ETT_COUNT && run_ff && tick) begin
      cnt_ff <= cnt_ff - 8'h01;
    end
  end

  // idle level is the inverse of the initial bit, toggles at terminal in modulo mode only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_ff <= 1'b1;
    end else if (!run_ff) begin
      out_ff <= ~aux_ff[ETT_INIT_BIT];
    end else if (term && !single_ff) begin
      out_ff <= ~out_ff;
    end
  end

  assign timer8_output = out_ff;

  // ****************************************
  // pin routing and interrupt requests
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pin_ff <= 1'b0;
    end else begin
      pin_ff <= pinsel_ff ? out_ff : aux_ff[ETT_PDATA_BIT];
    end
  end

  assign port3_bit4_pin     = pin_ff;
  assign timeout_irq        = flag_ff & tom_ff;
  assign capture_int_enable = capm_ff;

  // ****************************************
  // port2 bit0 edge source
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      p20_sync_ff <= 3'h0;
      p20_ff      <= 1'b0;
      edge_ev_ff  <= 1'b0;
    end else begin
      p20_sync_ff <= {p20_sync_ff[1:0], port2_bit0_pin};
      if (p20_sync_ff[1] == p20_sync_ff[2]) begin
        p20_ff <= p20_sync_ff[2];
      end
      edge_ev_ff <= (p20_sync_ff[1] == p20_sync_ff[2]) && (p20_sync_ff[2] != p20_ff)
                    && aux_ff[ETT_EDGSEL_BIT] && aux_ff[ETT_DEMOD_BIT];
    end
  end

  // mode changes are left to software with the timer stopped
  assign edge_sense = p20_ff & aux_ff[ETT_EDGSEL_BIT] & aux_ff[ETT_DEMOD_BIT];
  assign edge_event = edge_ev_ff;

  // ****************************************
  // checks
  // ****************************************
  logic [1:0] idle_cnt_ff;
  always_ff @(posedge ref_clk) begin
    if (!rst_n || run_ff) idle_cnt_ff <= 2'h0;
    else if (idle_cnt_ff != 2'h3) idle_cnt_ff <= idle_cnt_ff + 2'h1;
  end

  a_high_hold_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && hit_high |=> high_ff == $past(pwdata[7:0])) else $error("high hold not written");
  a_low_hold_wr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && hit_low |=> low_ff == $past(pwdata[7:0])) else $error("low hold not written");
  a_run_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && hit_ctrl && !stop_recovery |=> run_ff == $past(pwdata[ETT_RUN_BIT])
    && pre_ff == $past(pwdata[ETT_PRE_HI:ETT_PRE_LO])) else $error("control write lost");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && hit_ctrl && pwdata[ETT_FLAG_BIT] && !term |=> !flag_ff)
    else $error("flag not cleared");
  a_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    term |=> flag_ff) else $error("flag not set at terminal");
  a_mask_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    wr_en && hit_ctrl |=> capture_int_enable == $past(pwdata[ETT_CAPM_BIT])) else $error("capture mask wrong");
  a_pin_route: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ##1 port3_bit4_pin == ($past(pinsel_ff) ? $past(out_ff) : $past(aux_ff[ETT_PDATA_BIT])))
    else $error("pin routing wrong");
  a_idle_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    idle_cnt_ff == 2'h3 |-> timer8_output == ~$past(aux_ff[ETT_INIT_BIT])) else $error("idle level");
  a_reset_clear: assert property (@(posedge ref_clk)
    !rst_n |=> ctrl_rd == 8'h00) else $error("control not cleared by reset");
  a_smr_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stop_recovery |=> !run_ff && $stable(pre_ff) && $stable(tom_ff) && $stable(capm_ff))
    else $error("recovery disturbed kept bits");
  a_edge_src: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !aux_ff[ETT_DEMOD_BIT] |-> !edge_sense) else $error("edge source outside demod");
  a_reload_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    load_ev |=> cnt_ff == ($past(out_ff) ? $past(high_ff) : $past(low_ff)))
    else $error("wrong hold loaded");
  a_single_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)
    term && single_ff && !wr_en |=> !run_ff ##1 state_ff == ETT_IDLE)
    else $error("single pass did not stop");
  a_toggle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    term && !single_ff && !(wr_en && hit_ctrl) |=> timer8_output != $past(out_ff))
    else $error("output did not toggle");
  a_irq_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(flag_ff) && tom_ff |-> timeout_irq) else $error("missing time-out request");

  c_modulo_term: cover property (@(posedge ref_clk) disable iff (!rst_n) term && !single_ff);
  c_single_term: cover property (@(posedge ref_clk) disable iff (!rst_n) term && single_ff);
  c_flag_clear: cover property (@(posedge ref_clk) disable iff (!rst_n) flag_ff ##1 !flag_ff);
  c_edge_seen: cover property (@(posedge ref_clk) disable iff (!rst_n) edge_event);

endmodule // ett_timer8

// *** testbench/tb.sv ***
/*
  tb: self-checking bench for ett_timer8, driving APB, the recovery pulse
  and the port2 bit0 pin directly.
  assumes: ett_pkg compiled first, pready answers within the timeout.
*/
`timescale 1ns/1ps
module tb
  import ett_pkg::*;
;
  // ****************************************
  // signals and constants
  // ****************************************
  localparam logic [11:0] A_CTRL = {2'b00, ETT_CTRL_IDX, 2'b00};
  localparam logic [11:0] A_LOW  = {2'b00, ETT_LOW_IDX, 2'b00};
  localparam logic [11:0] A_HIGH = {2'b00, ETT_HIGH_IDX, 2'b00};
  localparam logic [11:0] A_AUX  = {2'b00, ETT_AUX_IDX, 2'b00};
  localparam logic [11:0] A_BAD  = 12'h030;
  localparam int          LIMIT  = 20000;

  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        stop_recovery  = 1'b0;
  logic        port2_bit0_pin = 1'b0;
  logic        port3_bit4_pin;
  logic        timer8_output;
  logic        timeout_irq;
  logic        capture_int_enable;
  logic        edge_sense;
  logic        edge_event;
  int          err_count = 0;
  int          checked   = 0;
  int          cycles    = 0;

  ett_timer8 u_ett_timer8 (
    .ref_clk            (ref_clk),
    .rst_n              (rst_n),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .pready             (pready),
    .prdata             (prdata),
    .pslverr            (pslverr),
    .stop_recovery      (stop_recovery),
    .port2_bit0_pin     (port2_bit0_pin),
    .port3_bit4_pin     (port3_bit4_pin),
    .timer8_output      (timer8_output),
    .timeout_irq        (timeout_irq),
    .capture_int_enable (capture_int_enable),
    .edge_sense         (edge_sense),
    .edge_event         (edge_event)
  );

  // clock and hang guard
  always #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic complete_run();
    if (err_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, then access until pready seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask

  // read and compare data and error
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic ex_err);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, ex_err});
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset_values();
    rd(A_CTRL, 32'h0, 1'b0);
    rd(A_LOW, 32'h0, 1'b0);
    rd(A_HIGH, 32'h0, 1'b0);
    chk({31'h0, timer8_output}, 32'h1);
    chk({31'h0, timeout_irq}, 32'h0);
  endtask

  task automatic t_registers();
    wr(A_LOW, 8'ha5);
    wr(A_HIGH, 8'h5a);
    rd(A_LOW, 32'ha5, 1'b0);
    rd(A_HIGH, 32'h5a, 1'b0);
    rd(A_BAD, 32'h0, 1'b1);
    wr(A_CTRL, 8'h1e);
    rd(A_CTRL, 32'h1e, 1'b0);
    chk({31'h0, capture_int_enable}, 32'h1);
    wr(A_CTRL, 8'h00);
    wait_cyc(1);
    chk({31'h0, capture_int_enable}, 32'h0);
    wr(A_AUX, 8'h01);
    wait_cyc(2);
    chk({31'h0, timer8_output}, 32'h0);
    wr(A_AUX, 8'h08);
    wait_cyc(2);
    chk({31'h0, timer8_output}, 32'h1);
    chk({31'h0, port3_bit4_pin}, 32'h1);
    wr(A_AUX, 8'h00);
  endtask

  // modulo run at one prescale, low hold 2 and high hold 3
  task automatic t_modulo(input logic [1:0] k);
    int n;
    wr(A_LOW, 8'h02);
    wr(A_HIGH, 8'h03);
    wr(A_CTRL, {3'b101, k, 3'b011});               // flag cleared at start
    n = 0;
    while (timer8_output !== 1'b0 && n < 200) begin
      n++;
      @(negedge ref_clk);
    end
    chk({31'h0, port3_bit4_pin}, 32'h1);
    n = 0;
    while (timer8_output === 1'b0 && n < 200) begin
      n++;
      @(negedge ref_clk);
    end
    chk(n, 3 << k);
    chk({31'h0, port3_bit4_pin}, 32'h0);
    n = 0;
    while (timer8_output === 1'b1 && n < 200) begin
      n++;
      @(negedge ref_clk);
    end
    chk(n, 4 << k);
    chk({31'h0, timeout_irq}, 32'h1);
    wr(A_CTRL, 8'h03);
    wait_cyc(2);
    chk({31'h0, timer8_output}, 32'h1);
  endtask

  task automatic t_flag();
    rd(A_CTRL, 32'h23, 1'b0);
    wr(A_CTRL, 8'h01);
    wait_cyc(1);
    chk({31'h0, timeout_irq}, 32'h0);
    wr(A_CTRL, 8'h03);
    rd(A_CTRL, 32'h23, 1'b0);
    wr(A_CTRL, 8'h22);
    rd(A_CTRL, 32'h02, 1'b0);
  endtask

  task automatic t_single();
    wr(A_CTRL, 8'hc0);
    wait_cyc(12);
    rd(A_CTRL, 32'h60, 1'b0);
    chk({31'h0, timer8_output}, 32'h1);
    wr(A_CTRL, 8'h20);
  endtask

  task automatic t_recovery();
    wr(A_CTRL, 8'hdf);
    @(posedge ref_clk);
    stop_recovery <= 1'b1;
    @(posedge ref_clk);
    stop_recovery <= 1'b0;
    rd(A_CTRL, 32'h1e, 1'b0);
    rd(A_HIGH, 32'h03, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(A_CTRL, 32'h0, 1'b0);
  endtask

  task automatic t_edge();
    int n;
    logic got;
    wr(A_AUX, 8'h06);
    wait_cyc(8);
    @(posedge ref_clk);
    port2_bit0_pin <= 1'b1;
    got = 1'b0;
    for (n = 0; n < 10; n++) begin
      @(negedge ref_clk);
      if (edge_event === 1'b1) got = 1'b1;
    end
    chk({31'h0, got}, 32'h1);
    chk({31'h0, edge_sense}, 32'h1);
    wr(A_AUX, 8'h02);
    wait_cyc(2);
    chk({31'h0, edge_sense}, 32'h0);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset_values();
    t_registers();
    for (int k = 0; k < 4; k++) begin
      t_modulo(k[1:0]);
    end
    t_flag();
    t_single();
    t_recovery();
    t_edge();
    complete_run();
  end

endmodule // tb
